// ===== psl_pkg.sv
// shared constants for the serial latch loader link
package psl_pkg;
	localparam int WORD_BITS = 24;
	localparam int BYTE_BITS = 8;
	localparam int SEL_LSB = 0;
	localparam logic [1:0] SEL_CONTROL = 2'h0;
	localparam logic [1:0] SEL_FEEDBACK = 2'h2;
	localparam logic [1:0] SEL_REFDIV = 2'h1;
	localparam logic [1:0] SEL_TEST = 2'h3;
	localparam int REF_RATIO_LSB = 2;
	localparam int REF_RATIO_BITS = 14;
	localparam int BACKLASH_LSB = 16;
	localparam int LOCK_PREC_BIT = 18;
	localparam int TEST_EN_BIT = 19;
	localparam int BAND_DIV_LSB = 20;
	localparam int RESERVED_LSB = 22;
	localparam logic [2:0] LOCK_CYCLES_FINE = 3'h5;
	localparam logic [2:0] LOCK_CYCLES_COARSE = 3'h3;
	localparam int CLOCK_PERIOD_NS = 8;
	localparam int SCLK_MAX_MHZ = 20;
	localparam int SCLK_MIN_PERIOD_NS = 1000 / SCLK_MAX_MHZ;
	// half period in system cycles, rounded up so the serial clock never exceeds its limit
	localparam int SCLK_HALF_CYCLES = (SCLK_MIN_PERIOD_NS / 2 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int BAND_CLOCK_LIMIT_MHZ = 1;
	localparam logic [7:0] ADDR_DATA = 8'h00;
	localparam logic [7:0] ADDR_GO = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
endpackage : psl_pkg

// ===== psl_link_if.sv
// three-wire link between the serial master and the latch loader
`timescale 1ns/1ps
interface psl_link_if;
	logic serialClock;
	logic serialData;
	logic loadStrobe;
	modport host (output serialClock, output serialData, output loadStrobe);
	modport device (input serialClock, input serialData, input loadStrobe);
endinterface : psl_link_if

// ===== psl_loader.sv
// device end: shift register, latch decode and reference-divider latch fields
//
// Summary of operation
// - capture data on each serial clock rise while strobe low
// - strobe rise transfers 24 bits to latch
// - host keeps serial clock at most 20 MHz
// - strobe low, three bytes, then strobe high
// - host drives with clock phase zero
// - bits 16-17 pick anti-backlash width
// - lock after five or three good cycles
// - test latch ignored while test bit zero
// - optional divider slows band-select clock
// - host writes reserved bits 22-23 zero
// - low two bits select destination latch
// - fourteen-bit reference divide ratio field
`timescale 1ns/1ps
module psl_loader import psl_pkg::*; (
	input wire logic clock, // system clock
	input wire logic sys_rst, // synchronous reset
	psl_link_if.device link, // serial link
	output logic [WORD_BITS-1:0] controlLatch, // control latch
	output logic [WORD_BITS-1:0] feedbackLatch, // feedback divider latch
	output logic [WORD_BITS-1:0] testLatch, // factory test latch as seen by core
	output logic [REF_RATIO_BITS-1:0] referenceDivideRatio, // divide ratio
	output logic [1:0] backlashWidth, // anti-backlash select
	output logic [2:0] lockCycleCount, // good cycles needed for lock
	output logic factoryTestEnable, // test latch honoured
	output logic [1:0] bandClockDivide, // band-select divider code
	output logic loadPulse // one cycle per completed word
);
	typedef struct packed {
		logic sclkPrev;
		logic strobePrev;
		logic [WORD_BITS-1:0] shiftReg;
		logic [WORD_BITS-1:0] ctrl;
		logic [WORD_BITS-1:0] fdbk;
		logic [WORD_BITS-1:0] refd;
		logic [WORD_BITS-1:0] test;
		logic load;
	} psl_dev_s;
	psl_dev_s state_reg, state_next;

	always_comb begin
		state_next = state_reg;
		state_next.sclkPrev = link.serialClock;
		state_next.strobePrev = link.loadStrobe;
		state_next.load = 1'b0;
		if (link.serialClock && !state_reg.sclkPrev && !link.loadStrobe) begin
			state_next.shiftReg = {state_reg.shiftReg[WORD_BITS-2:0], link.serialData};
		end
		if (link.loadStrobe && !state_reg.strobePrev) begin
			state_next.load = 1'b1;
			case (state_reg.shiftReg[SEL_LSB+:2])
				SEL_CONTROL: state_next.ctrl = state_reg.shiftReg;
				SEL_FEEDBACK: state_next.fdbk = state_reg.shiftReg;
				SEL_REFDIV: state_next.refd = state_reg.shiftReg;
				default: state_next.test = state_reg.shiftReg;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			// the strobe idles high, so its edge detector starts high: no false load after reset
			state_reg <= '{strobePrev: 1'b1, default: '0};
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------
	// field outputs
	// ----------------------------------------
	assign controlLatch = state_reg.ctrl;
	assign feedbackLatch = state_reg.fdbk;
	assign referenceDivideRatio = state_reg.refd[REF_RATIO_LSB+:REF_RATIO_BITS];
	assign backlashWidth = state_reg.refd[BACKLASH_LSB+:2];
	assign lockCycleCount = state_reg.refd[LOCK_PREC_BIT] ? LOCK_CYCLES_FINE : LOCK_CYCLES_COARSE;
	assign factoryTestEnable = state_reg.refd[TEST_EN_BIT];
	assign testLatch = factoryTestEnable ? state_reg.test : '0;
	// code zero leaves the band logic on the undivided reference output
	assign bandClockDivide = state_reg.refd[BAND_DIV_LSB+:2];
	assign loadPulse = state_reg.load;
endmodule : psl_loader

// ===== psl_host.sv
// host end: register port and 24-bit serial master
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module psl_host import psl_pkg::*; (
	input wire logic clock, // system clock
	input wire logic sys_rst, // synchronous reset
	input wire logic [7:0] regAddr, // register address
	input wire logic [31:0] regWrData, // write data
	input wire logic regWrite, // write strobe
	input wire logic regRead, // read strobe
	output logic [31:0] regRdData, // read data, next cycle
	psl_link_if.host link // serial link
);
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_LOW = 4'h2,
		ST_HIGH = 4'h4,
		ST_LOAD = 4'h8
	} psl_host_e;
	typedef struct packed {
		psl_host_e st;
		logic [WORD_BITS-1:0] word;
		logic [WORD_BITS-1:0] shiftReg;
		logic [4:0] bitCount;
		logic [7:0] halfCount;
		logic sclk;
		logic sdata;
		logic strobe;
		logic done;
		logic [31:0] rd;
	} psl_host_s;
	psl_host_s state_reg, state_next;

	always_comb begin
		state_next = state_reg;
		state_next.rd = 32'h0;
		if (regRead) begin
			if (regAddr == ADDR_DATA) begin
				state_next.rd = {8'h00, state_reg.word};
			end else if (regAddr == ADDR_STATUS) begin
				state_next.rd = {30'h0, state_reg.done, state_reg.st != ST_IDLE};
			end
		end
		if (regWrite && regAddr == ADDR_DATA) begin
			// in reference-divider words, reserved bits 22-23 and the test bit are forced clear regardless of what software wrote
			state_next.word = regWrData[WORD_BITS-1:0];
			if (regWrData[SEL_LSB+:2] == SEL_REFDIV) begin
				state_next.word[RESERVED_LSB+:2] = 2'h0;
				state_next.word[TEST_EN_BIT] = 1'b0;
			end
		end
		if (regWrite && regAddr == ADDR_STATUS && regWrData[1]) begin
			state_next.done = 1'b0;
		end
		case (state_reg.st)
			ST_IDLE: begin
				if (regWrite && regAddr == ADDR_GO) begin
					state_next.st = ST_LOW;
					state_next.strobe = 1'b0;
					state_next.shiftReg = state_reg.word;
					state_next.sdata = state_reg.word[WORD_BITS-1];
					state_next.bitCount = 5'h0;
					state_next.halfCount = 8'h0;
				end
			end
			ST_LOW: begin
				state_next.halfCount = state_reg.halfCount + 8'h1;
				if (state_reg.halfCount == 8'(SCLK_HALF_CYCLES - 1)) begin
					state_next.halfCount = 8'h0;
					state_next.sclk = 1'b1;
					state_next.st = ST_HIGH;
				end
			end
			ST_HIGH: begin
				state_next.halfCount = state_reg.halfCount + 8'h1;
				if (state_reg.halfCount == 8'(SCLK_HALF_CYCLES - 1)) begin
					state_next.halfCount = 8'h0;
					state_next.sclk = 1'b0;
					state_next.shiftReg = {state_reg.shiftReg[WORD_BITS-2:0], 1'b0};
					state_next.sdata = state_reg.shiftReg[WORD_BITS-2];
					state_next.bitCount = state_reg.bitCount + 5'h1;
					state_next.st = (state_reg.bitCount == 5'(WORD_BITS - 1)) ? ST_LOAD : ST_LOW;
				end
			end
			ST_LOAD: begin
				state_next.halfCount = state_reg.halfCount + 8'h1;
				if (state_reg.halfCount == 8'(SCLK_HALF_CYCLES - 1)) begin
					state_next.strobe = 1'b1;
					state_next.done = 1'b1;
					state_next.st = ST_IDLE;
				end
			end
			default: state_next.st = ST_IDLE;
		endcase
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_reg <= '{st: ST_IDLE, strobe: 1'b1, default: '0};
		end else begin
			state_reg <= state_next;
		end
	end

	assign regRdData = state_reg.rd;
	assign link.serialClock = state_reg.sclk;
	assign link.serialData = state_reg.sdata;
	assign link.loadStrobe = state_reg.strobe;
endmodule : psl_host

// ===== psl_checker.sv
// link checker: timing, framing and content of words on the wires
`timescale 1ns/1ps
module psl_checker import psl_pkg::*; (
	input wire logic clock, // clock
	input wire logic sys_rst, // reset
	input wire logic serialClock, // link clock
	input wire logic serialData, // link data
	input wire logic loadStrobe // strobe
);
	logic [4:0] bitCount;
	logic [23:0] shiftWord;
	always_ff @(posedge clock) begin
		if (sys_rst || $fell(loadStrobe)) begin
			bitCount <= 5'h0;
		end else if ($rose(serialClock)) begin
			bitCount <= bitCount + 5'h1;
			shiftWord <= {shiftWord[22:0], serialData};
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	property p_high; $rose(serialClock) |-> serialClock[*4]; endproperty
	a_high: assert property (p_high) else $error("clock high too short");
	property p_low; $fell(serialClock) |-> !serialClock[*4]; endproperty
	a_low: assert property (p_low) else $error("clock low too short");
	property p_data; $changed(serialData) |-> !serialClock; endproperty
	a_data: assert property (p_data) else $error("data moved while clock high");
	property p_open; $fell(loadStrobe) |-> !serialClock ##1 !serialClock; endproperty
	a_open: assert property (p_open) else $error("clock high at frame start");
	property p_len; $rose(loadStrobe) |-> bitCount == 5'h18; endproperty
	a_len: assert property (p_len) else $error("frame not 24 bits");
	property p_idle; loadStrobe |-> !serialClock; endproperty
	a_idle: assert property (p_idle) else $error("clock runs outside frame");
	property p_bit; $rose(serialClock) |-> !loadStrobe && bitCount < 5'h18; endproperty
	a_bit: assert property (p_bit) else $error("bit outside frame");
	property p_resv;
		$rose(loadStrobe) && shiftWord[1:0] == SEL_REFDIV |-> shiftWord[23:22] == 2'h0 && !shiftWord[19];
	endproperty
	a_resv: assert property (p_resv) else $error("reserved or test bit set");
endmodule : psl_checker

// ===== tb_top.sv
// testbench: host and loader joined by the link, scoreboard per load
`timescale 1ns/1ps
module tb_top;
	import psl_pkg::*;
	logic clock = 0, sys_rst = 1, regWrite = 0, regRead = 0, fte, lp;
	logic [7:0] regAddr = 8'h0;
	logic [31:0] regWrData = 32'h0, regRdData, d;
	logic [23:0] cl, fl, tl, w, e, expQ[$];
	logic [13:0] rr;
	logic [1:0] bw, bd;
	logic [2:0] lc;
	int n_errors = 0, cmp_count = 0, cyc = 0;
	psl_link_if link();
	psl_host psl_host_i(.clock(clock), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
		.regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .link(link.host));
	psl_loader psl_loader_i(.clock(clock), .sys_rst(sys_rst), .link(link.device), .controlLatch(cl),
		.feedbackLatch(fl), .testLatch(tl), .referenceDivideRatio(rr), .backlashWidth(bw),
		.lockCycleCount(lc), .factoryTestEnable(fte), .bandClockDivide(bd), .loadPulse(lp));
	psl_checker psl_checker_i(.clock(clock), .sys_rst(sys_rst), .serialClock(link.serialClock),
		.serialData(link.serialData), .loadStrobe(link.loadStrobe));
	always #4 clock = ~clock;
	task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clock);
		regAddr <= a;
		regWrData <= v;
		regWrite <= 1'b1;
		@(posedge clock);
		regWrite <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge clock);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clock);
		regRead <= 1'b0;
		#1 d = regRdData;
	endtask : rd
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : finish_test
	// a load with nothing expected is itself a fault
	always @(negedge clock) if (lp === 1'b1) begin
		if (expQ.size() == 0) begin
			n_errors++;
			$display("mismatch at %0t: got load %h expected %h", $time, lp, 1'b0);
		end else begin
			e = expQ.pop_front();
			case (e[1:0])
				SEL_CONTROL: cmp(cl, e);
				SEL_FEEDBACK: cmp(fl, e);
				SEL_REFDIV: cmp({rr, bw, lc, fte, bd}, {e[15:2], e[17:16], e[18] ? LOCK_CYCLES_FINE : LOCK_CYCLES_COARSE,
					1'b0, e[21:20]});
				default: cmp(tl, 24'h0);
			endcase
		end
	end
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			finish_test();
		end
	end
	initial begin
		void'($urandom(32'h012f88f0));
		repeat (6) @(posedge clock);
		sys_rst <= 1'b0;
		for (int i = 0; i < 12; i++) begin
			w = 24'($urandom);
			w[1:0] = i[1:0];
			// walk both lock precision settings across the reference-divider words
			if (i[1:0] == 2'h1) w[LOCK_PREC_BIT] = i[2];
			wr(ADDR_DATA, {8'h0, w});
			if (w[1:0] == SEL_REFDIV) w = w & 24'h37ffff;
			rd(ADDR_DATA);
			cmp(d[23:0], w);
			expQ.push_back(w);
			wr(ADDR_GO, 32'h1);
			wr(ADDR_GO, 32'h1); // second start while busy must be dropped
			rd(ADDR_STATUS);
			for (int k = 0; k < 200 && d[1] !== 1'b1; k++) rd(ADDR_STATUS);
			cmp(d[23:0], 24'h2);
			wr(ADDR_STATUS, 32'h2);
			rd(8'h0c);
			cmp(d[23:0], 24'h0);
			$display("word %0d done", i);
		end
		cmp(24'(expQ.size()), 24'h0);
		finish_test();
	end
endmodule : tb_top
